// File: shared/cell_pkg.sv
`default_nettype none

package cell_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int LINK_W = 8;
  localparam int WORD_W = 16;
  localparam int ADR_W = 5;
  localparam int POS_W = 6;

  // ----------------------------------------------------------------------
  // Cell geometry
  // ----------------------------------------------------------------------
  // User-side word count runs 0x00 to 0x1B, 27 words of 16 bits.
  localparam logic [ADR_W-1:0] LAST_WORD = 5'h1B;
  // Link byte index of the final byte, 53-byte and 54-byte cells.
  localparam logic [POS_W-1:0] LAST_BYTE_53 = 6'h34;
  localparam logic [POS_W-1:0] LAST_BYTE_54 = 6'h35;
  // User-side byte position of the final byte of the 54-byte cell.
  localparam logic [POS_W-1:0] USER_LAST = 6'h35;
  // Fifth header byte, and the extra sixth byte copied from it.
  localparam logic [POS_W-1:0] HEC_POS = 6'h04;
  localparam logic [POS_W-1:0] UDF2_POS = 6'h05;
  // Reset values.
  localparam logic [LINK_W-1:0] BYTE_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [POS_W-1:0] POS_RST = 6'h00;

  // Link index of the final byte for the selected cell length.
  function automatic logic [POS_W-1:0] last_byte(input logic cell_54);
    last_byte = cell_54 ? LAST_BYTE_54 : LAST_BYTE_53;
  endfunction : last_byte

endpackage : cell_pkg

`default_nettype wire

// File: shared/cell_link_if.sv
`default_nettype none

// --------------------------------------------------------------------------
// Eight-bit point-to-point cell link, one lane each way
// --------------------------------------------------------------------------
interface cell_link_if;
  logic ingress_space_flag;
  logic ingress_select_n;
  logic ingress_cell_start;
  logic [cell_pkg::LINK_W-1:0] ingress_byte_in;
  logic egress_cell_ready_flag;
  logic egress_select_n;
  logic egress_cell_start;
  logic [cell_pkg::LINK_W-1:0] egress_byte_out;

  // Physical-layer port end.
  modport phy (
    output ingress_space_flag,
    input ingress_select_n,
    input ingress_cell_start,
    input ingress_byte_in,
    output egress_cell_ready_flag,
    input egress_select_n,
    output egress_cell_start,
    output egress_byte_out
  );

  // Link-layer master end.
  modport link (
    input ingress_space_flag,
    output ingress_select_n,
    output ingress_cell_start,
    output ingress_byte_in,
    input egress_cell_ready_flag,
    output egress_select_n,
    input egress_cell_start,
    input egress_byte_out
  );
endinterface : cell_link_if

`default_nettype wire

// File: verilog/word_counter.sv
`default_nettype none

// --------------------------------------------------------------------------
// Wrapping word counter for the user-side word address
// --------------------------------------------------------------------------
module word_counter #(
  parameter int W = cell_pkg::ADR_W,
  parameter logic [W-1:0] LAST = cell_pkg::LAST_WORD
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control.
  input wire logic step,
  input wire logic clear,
  // Count.
  output logic [W-1:0] count
);

  logic [W-1:0] count_reg;

  // Clear wins over a step, so an aborted cell always restarts at zero.
  // The count rests on LAST for one cycle to mark a whole cell, then returns
  // to zero by itself, so the next cell's first word is numbered zero.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clear)
    begin
      count_reg <= '0;
    end
    else if (count_reg == LAST)
    begin
      count_reg <= '0;
    end
    else if (step)
    begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign count = count_reg;

endmodule : word_counter

`default_nettype wire

// File: verilog/phy_cell_port.sv
`default_nettype none

// Overview of operation
// - Low length bit: 53 link bytes, UDF2 added/dropped
// - One 8-bit lane each way, one master
// - Space flag follows user write-ready
// - Master starts no cell while space flag low
// - Master selects ingress by driving select low
// - Cell start may come with selection
// - After start, accept 53 or 54 bytes
// - Master may deselect ingress after final byte
// - Selected stall between cells keeps state
// - Back-to-back ingress cells are accepted
// - Cell-ready flag follows user read-ready
// - Master waits while cell-ready flag low
// - Master selects egress by driving select low
// - Egress cell start marks first byte
// - Egress cell bytes go out without pause
// - Master may deselect egress after final byte
// - Still selected and cell waiting: back-to-back
// - Nothing waiting: stay idle while selected
// - Reset clears and holds every register
// - 53-byte ingress copies fifth byte as sixth
// - Word count 00 to 1B, then zero
module phy_cell_port (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link to the master.
  cell_link_if.phy link,
  // Cell length: low for 53-byte link cells, high for 54.
  input wire logic cell_54,
  // User write side.
  input wire logic write_ready,
  output logic w_phy_act,
  output logic w_enable,
  output logic [cell_pkg::ADR_W-1:0] w_adr,
  output logic [cell_pkg::WORD_W-1:0] w_data,
  // User read side.
  input wire logic egress_cell_waiting,
  output logic r_buf_en,
  output logic [cell_pkg::ADR_W-1:0] r_adr,
  input wire logic [cell_pkg::WORD_W-1:0] r_data
);

  // ------------------------------------------------------------------------
  // Ingress: link bytes into user words
  // ------------------------------------------------------------------------
  logic tx_busy_reg;
  logic [cell_pkg::POS_W-1:0] tx_pos_reg;
  logic [cell_pkg::LINK_W-1:0] tx_hi_reg;
  logic w_enable_reg;
  logic [cell_pkg::WORD_W-1:0] w_data_reg;
  logic w_phy_act_reg;
  logic tx_sel;
  logic tx_start;
  logic tx_take;
  logic tx_dup;
  logic tx_emit;
  logic [cell_pkg::POS_W-1:0] tx_pos;

  // The space flag is a straight copy of the user's write-ready.
  assign link.ingress_space_flag = write_ready;

  // A byte is taken only while selected; bytes seen while deselected are
  // ignored, so a master that pauses mid-cell loses nothing.
  always_comb
  begin
    tx_sel = !link.ingress_select_n;
    tx_start = tx_sel && link.ingress_cell_start;
    tx_take = tx_start || (tx_sel && tx_busy_reg);
    tx_pos = tx_start ? cell_pkg::POS_RST : tx_pos_reg;
    tx_dup = !cell_54 && (tx_pos == cell_pkg::HEC_POS);
    tx_emit = tx_take && (tx_pos[0] || tx_dup);
  end

  // Cell in progress; ends after the final user byte position.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_busy_reg <= 1'b0;
    end
    else if (tx_take)
    begin
      tx_busy_reg <= (tx_pos != cell_pkg::USER_LAST);
    end
  end

  // User byte position; the copied fifth byte skips one position.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_pos_reg <= cell_pkg::POS_RST;
    end
    else if (tx_take)
    begin
      tx_pos_reg <= tx_dup ? tx_pos + 6'h02 : tx_pos + 6'h01;
    end
  end

  // High byte of the word under assembly.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_hi_reg <= cell_pkg::BYTE_RST;
    end
    else if (tx_take && !tx_pos[0])
    begin
      tx_hi_reg <= link.ingress_byte_in;
    end
  end

  // One-cycle word strobe with its data, high byte first.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      w_enable_reg <= 1'b0;
      w_data_reg <= cell_pkg::WORD_RST;
    end
    else
    begin
      w_enable_reg <= tx_emit;
      if (tx_emit)
      begin
        w_data_reg <= tx_pos[0] ? {tx_hi_reg, link.ingress_byte_in}
                                : {link.ingress_byte_in, link.ingress_byte_in};
      end
    end
  end

  // Port-active follows selection one cycle late, and drops on any deselected cycle, stalls between cells included.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      w_phy_act_reg <= 1'b0;
    end
    else
    begin
      w_phy_act_reg <= tx_sel;
    end
  end

  // Address steps after each strobe; a new start inside a cell resets it,
  // which tells the user to drop the partial cell.
  word_counter #(
    .W(cell_pkg::ADR_W),
    .LAST(cell_pkg::LAST_WORD)
  ) u_w_count (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(w_enable_reg),
    .clear(tx_start && tx_busy_reg),
    .count(w_adr)
  );

  assign w_enable = w_enable_reg;
  assign w_data = w_data_reg;
  assign w_phy_act = w_phy_act_reg;

  // ------------------------------------------------------------------------
  // Egress: user words out as link bytes
  // ------------------------------------------------------------------------
  logic rx_busy_reg;
  logic [cell_pkg::POS_W-1:0] rx_idx_reg;
  logic rd_valid_reg;
  logic [cell_pkg::LINK_W-1:0] rx_lo_reg;
  logic [cell_pkg::LINK_W-1:0] rx_byte_reg;
  logic rx_start_reg;
  logic rx_last;
  logic rx_launch;
  logic rx_next_hi;
  logic [cell_pkg::POS_W-1:0] rx_next;
  logic [cell_pkg::POS_W-1:0] rx_next_user;

  assign link.egress_cell_ready_flag = egress_cell_waiting;

  // A word is requested one cycle ahead of the cycle that loads its high
  // byte; in 53-byte mode the third and fourth requests run back to back
  // because the sixth user byte is never sent.
  always_comb
  begin
    rx_last = rx_busy_reg && (rx_idx_reg == cell_pkg::last_byte(cell_54));
    rx_launch = !link.egress_select_n && egress_cell_waiting
                && (!rx_busy_reg || rx_last);
    rx_next = rx_idx_reg + 6'h01;
    rx_next_user = (!cell_54 && rx_next >= cell_pkg::UDF2_POS) ? rx_next + 6'h01
                                                               : rx_next;
    rx_next_hi = !rx_next_user[0];
    r_buf_en = rx_launch || (rx_busy_reg && !rx_last && rx_next_hi);
  end

  // Busy from launch to the final byte; once started nothing stops it.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_busy_reg <= 1'b0;
      rx_idx_reg <= cell_pkg::POS_RST;
    end
    else if (rx_launch)
    begin
      rx_busy_reg <= 1'b1;
      rx_idx_reg <= cell_pkg::POS_RST;
    end
    else if (rx_busy_reg)
    begin
      rx_busy_reg <= !rx_last;
      rx_idx_reg <= rx_next;
    end
  end

  // Requested word is on the user data pins one cycle after the request.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_valid_reg <= 1'b0;
      rx_lo_reg <= cell_pkg::BYTE_RST;
    end
    else
    begin
      rd_valid_reg <= r_buf_en;
      if (rd_valid_reg)
      begin
        rx_lo_reg <= r_data[7:0];
      end
    end
  end

  // Link byte and start mark change only on the rising edge.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_byte_reg <= cell_pkg::BYTE_RST;
      rx_start_reg <= 1'b0;
    end
    else
    begin
      rx_start_reg <= rx_busy_reg && (rx_idx_reg == cell_pkg::POS_RST);
      if (rx_busy_reg)
      begin
        rx_byte_reg <= rd_valid_reg ? r_data[15:8] : rx_lo_reg;
      end
    end
  end

  // Read address steps with each request and returns to zero after 0x1B.
  word_counter #(
    .W(cell_pkg::ADR_W),
    .LAST(cell_pkg::LAST_WORD)
  ) u_r_count (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(r_buf_en),
    .clear(1'b0),
    .count(r_adr)
  );

  assign link.egress_byte_out = rx_byte_reg;
  assign link.egress_cell_start = rx_start_reg;

endmodule : phy_cell_port

`default_nettype wire

// File: verilog/link_master.sv
`default_nettype none

// --------------------------------------------------------------------------
// Link-layer master end of the cell link
// --------------------------------------------------------------------------
module link_master (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link to the port.
  cell_link_if.link link,
  // Cell length: low for 53-byte link cells, high for 54.
  input wire logic cell_54,
  // Outgoing byte stream.
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic [cell_pkg::LINK_W-1:0] tx_data,
  output logic tx_ready,
  // Incoming byte stream.
  input wire logic rx_ready,
  output logic rx_valid,
  output logic rx_first,
  output logic [cell_pkg::LINK_W-1:0] rx_data
);

  // ------------------------------------------------------------------------
  // Ingress sender
  // ------------------------------------------------------------------------
  logic tx_busy_reg;
  logic [cell_pkg::POS_W-1:0] tx_cnt_reg;
  logic sel_n_reg;
  logic soc_reg;
  logic [cell_pkg::LINK_W-1:0] byte_reg;
  logic tx_taken;
  logic tx_start;
  logic tx_move;

  // A new cell waits for the space flag; inside a cell bytes always flow.
  // A non-first byte offered between cells is consumed and dropped.
  always_comb
  begin
    tx_ready = tx_busy_reg || link.ingress_space_flag;
    tx_taken = tx_valid && tx_ready;
    tx_start = tx_taken && tx_first;
    tx_move = tx_taken && (tx_start || tx_busy_reg);
  end

  // Select drops for each byte sent and rises on any idle cycle, which
  // both stalls between cells and deselects after the final byte.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sel_n_reg <= 1'b1;
      soc_reg <= 1'b0;
      byte_reg <= cell_pkg::BYTE_RST;
    end
    else
    begin
      sel_n_reg <= !tx_move;
      soc_reg <= tx_start;
      if (tx_move)
      begin
        byte_reg <= tx_data;
      end
    end
  end

  // Byte count of the cell being sent.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= cell_pkg::POS_RST;
    end
    else if (tx_start)
    begin
      tx_busy_reg <= 1'b1;
      tx_cnt_reg <= 6'h01;
    end
    else if (tx_move)
    begin
      tx_busy_reg <= (tx_cnt_reg != cell_pkg::last_byte(cell_54));
      tx_cnt_reg <= tx_cnt_reg + 6'h01;
    end
  end

  assign link.ingress_select_n = sel_n_reg;
  assign link.ingress_cell_start = soc_reg;
  assign link.ingress_byte_in = byte_reg;

  // ------------------------------------------------------------------------
  // Egress receiver
  // ------------------------------------------------------------------------
  logic rx_busy_reg;
  logic [cell_pkg::POS_W-1:0] rx_cnt_reg;
  logic rx_valid_reg;
  logic rx_first_reg;
  logic [cell_pkg::LINK_W-1:0] rx_data_reg;

  // Stay selected through a cell; at its final byte keep the port only if
  // the user can take another and one is waiting.
  assign link.egress_select_n = !((rx_busy_reg
      && rx_cnt_reg != cell_pkg::last_byte(cell_54))
      || (rx_ready && link.egress_cell_ready_flag));

  // Cell tracking from the start mark; the port never pauses a cell.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= cell_pkg::POS_RST;
    end
    else if (link.egress_cell_start)
    begin
      rx_busy_reg <= 1'b1;
      rx_cnt_reg <= 6'h01;
    end
    else if (rx_busy_reg)
    begin
      rx_busy_reg <= (rx_cnt_reg != cell_pkg::last_byte(cell_54));
      rx_cnt_reg <= rx_cnt_reg + 6'h01;
    end
  end

  // Registered byte stream toward the user; there is no back-pressure.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_valid_reg <= 1'b0;
      rx_first_reg <= 1'b0;
      rx_data_reg <= cell_pkg::BYTE_RST;
    end
    else
    begin
      rx_valid_reg <= link.egress_cell_start || rx_busy_reg;
      rx_first_reg <= link.egress_cell_start;
      rx_data_reg <= link.egress_byte_out;
    end
  end

  assign rx_valid = rx_valid_reg;
  assign rx_first = rx_first_reg;
  assign rx_data = rx_data_reg;

endmodule : link_master

`default_nettype wire

// File: sim/cell_link_props.sv
`default_nettype none

// ----------------------------------------------------------------------
// Cell link protocol checker
// ----------------------------------------------------------------------
module cell_link_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Cell length and user readiness.
  input wire logic cell_54,
  input wire logic write_ready,
  input wire logic egress_cell_waiting,
  // Link signals.
  input wire logic ingress_space_flag,
  input wire logic ingress_select_n,
  input wire logic ingress_cell_start,
  input wire logic egress_cell_ready_flag,
  input wire logic egress_select_n,
  input wire logic egress_cell_start
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] eg_idx_reg;
  logic pend_reg;
  logic fin, pen, idle, mid, take_idle, take_pen;

  // Egress position as seen on the wire. The port decides on a following cell while
  // the penultimate byte stands, so that byte 0 can follow the final byte at once.
  // The cycle after any accepted request is pending until its start.
  assign fin = eg_idx_reg == (cell_54 ? 6'h35 : 6'h34);
  assign pen = eg_idx_reg == (cell_54 ? 6'h34 : 6'h33);
  assign idle = !pend_reg && !egress_cell_start && (eg_idx_reg == 6'h00 || fin);
  assign mid = egress_cell_start || (eg_idx_reg != 6'h00 && !fin);
  assign take_idle = idle && !egress_select_n && egress_cell_ready_flag;
  assign take_pen = pen && !egress_select_n && egress_cell_ready_flag;

  // Byte index of the egress cell; a start always restarts it.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      eg_idx_reg <= 6'h00;
    else if (egress_cell_start)
      eg_idx_reg <= 6'h01;
    else if (fin)
      eg_idx_reg <= 6'h00;
    else if (eg_idx_reg != 6'h00)
      eg_idx_reg <= eg_idx_reg + 6'h01;
  end

  // Marks the cycle between an accepted request and its start.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      pend_reg <= 1'b0;
    else
      pend_reg <= take_idle || take_pen;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_space_flag_mirror: assert property (ingress_space_flag == write_ready)
    else $error("ingress space flag differs from write ready");
  a_ready_flag_mirror: assert property (egress_cell_ready_flag == egress_cell_waiting)
    else $error("egress ready flag differs from cell waiting");
  a_idle_take_start: assert property (take_idle |-> ##2 egress_cell_start)
    else $error("egress cell did not start two cycles after request");
  a_back_to_back: assert property (take_pen |-> ##2 egress_cell_start)
    else $error("back to back egress cell missing");
  a_start_has_cause: assert property
    (egress_cell_start |-> $past(take_idle, 2) || $past(take_pen, 2))
    else $error("egress cell started without request");
  a_mid_cell_selected: assert property (mid |-> !egress_select_n)
    else $error("master deselected egress mid cell");
  a_master_waits: assert property (!mid && !egress_cell_ready_flag |-> egress_select_n)
    else $error("master selected egress with no cell ready");
  a_ingress_selected: assert property (ingress_cell_start |-> !ingress_select_n)
    else $error("ingress cell start while not selected");
  a_ingress_space: assert property (ingress_cell_start |-> $past(ingress_space_flag))
    else $error("ingress cell started while space flag low");

  // Main scenarios reached.
  c_idle_take: cover property (take_idle);
  c_pen_take: cover property (take_pen);
  c_ingress_start: cover property (ingress_cell_start ##1 !ingress_select_n);

endmodule : cell_link_props

`default_nettype wire

// File: sim/test_utopia_l1_phy_cell_port.sv
`default_nettype none

module test_utopia_l1_phy_cell_port;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cell_54 = 1'b1;
  logic write_ready = 1'b0;
  logic egress_cell_waiting = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_first = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_ready = 1'b0;
  logic [15:0] r_data = 16'h0000;
  logic w_phy_act, w_enable, r_buf_en, tx_ready, rx_valid, rx_first;
  logic [4:0] w_adr, r_adr;
  logic [15:0] w_data;
  logic [7:0] rx_data;
  logic [15:0] rd_buf [27];
  logic [20:0] wq [$];
  logic [8:0] rq [$];
  int miscompares = 0;
  int tests_run = 0;
  int starts = 0;

  cell_link_if link ();
  phy_cell_port u_phy_cell_port (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .cell_54(cell_54), .write_ready(write_ready), .w_phy_act(w_phy_act),
    .w_enable(w_enable), .w_adr(w_adr), .w_data(w_data),
    .egress_cell_waiting(egress_cell_waiting), .r_buf_en(r_buf_en), .r_adr(r_adr),
    .r_data(r_data));
  link_master u_link_master (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .cell_54(cell_54), .tx_valid(tx_valid), .tx_first(tx_first), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_data(rx_data));
  cell_link_props u_cell_link_props (.ref_clk(ref_clk), .rst_n(rst_n), .cell_54(cell_54),
    .write_ready(write_ready), .egress_cell_waiting(egress_cell_waiting),
    .ingress_space_flag(link.ingress_space_flag), .ingress_select_n(link.ingress_select_n),
    .ingress_cell_start(link.ingress_cell_start),
    .egress_cell_ready_flag(link.egress_cell_ready_flag),
    .egress_select_n(link.egress_select_n), .egress_cell_start(link.egress_cell_start));

  // Free-running 100 MHz clock.
  always #5 ref_clk = ~ref_clk;

  // User read buffer; the word is only good in the cycle after a request.
  always @(posedge ref_clk)
    r_data <= #1 (r_buf_en === 1'b1) ? rd_buf[r_adr] : ~r_data;

  // ----------------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic fail(input string what);
    miscompares++;
    $display("ERROR %0t %s timed out", $time, what);
    results();
  endtask : fail

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  // Oldest note is taken off whenever a word or a byte appears.
  always @(posedge ref_clk)
  begin
    if (rst_n && w_enable === 1'b1)
      chk({3'h0, w_adr, w_data}, wq.size() ? wq.pop_front() : 24'hff_ffff, "word");
    if (rst_n && w_enable === 1'b1)
      chk({23'h0, w_phy_act}, 24'h00_0001, "port active");
    if (rst_n && rx_valid === 1'b1)
      chk({15'h0, rx_first, rx_data}, rq.size() ? rq.pop_front() : 24'hff_ffff, "byte");
    if (rst_n && rx_first === 1'b1)
      starts++;
  end

  // ----------------------------------------------------------------------
  // Traffic tasks
  // ----------------------------------------------------------------------
  // Sends whole cells back to back; the user words expected are noted first.
  task automatic send(input int cells);
    logic [7:0] lb [54];
    logic [7:0] ub [54];
    int n, j, t;
    logic ok;
    n = cell_54 ? 54 : 53;
    for (int c = 0; c < cells; c++)
    begin
      j = 0;
      for (int i = 0; i < n; i++)
      begin
        lb[i] = 8'($urandom);
        ub[j] = lb[i];
        j++;
        if (!cell_54 && i == 4)
        begin
          ub[j] = lb[i];
          j++;
        end
      end
      for (int k = 0; k < 27; k++)
        wq.push_back({5'(k), ub[2 * k], ub[2 * k + 1]});
      for (int i = 0; i < n; i++)
      begin
        tx_valid = 1'b1;
        tx_first = i == 0;
        tx_data = lb[i];
        t = 0;
        do
        begin
          @(posedge ref_clk);
          ok = tx_ready;
          #1;
          t++;
        end
        while (ok !== 1'b1 && t < 300);
        if (ok !== 1'b1)
          fail("transmit");
      end
    end
    tx_valid = 1'b0;
    tx_first = 1'b0;
  endtask : send

  // Waits until every note has been matched.
  task automatic drain();
    int t;
    t = 0;
    while ((wq.size() || rq.size()) && t < 500)
    begin
      tick();
      t++;
    end
    if (wq.size() || rq.size())
      fail("drain");
  endtask : drain

  // Offers cells from the read buffer; the master first holds off, then takes them.
  task automatic recv(input int cells);
    int t;
    for (int k = 0; k < 27; k++)
      rd_buf[k] = 16'($urandom);
    for (int c = 0; c < cells; c++)
      for (int i = 0; i < 54; i++)
        if (cell_54 || i != 5)
          rq.push_back({i == 0, i % 2 ? rd_buf[i / 2][7:0] : rd_buf[i / 2][15:8]});
    starts = 0;
    egress_cell_waiting = 1'b1;
    repeat (20) tick();
    chk(24'(link.egress_cell_ready_flag), 24'h00_0001, "ready flag");
    chk(24'(link.egress_select_n), 24'h00_0001, "egress select");
    rx_ready = 1'b1;
    t = 0;
    while (starts < cells && t < 2000)
    begin
      tick();
      t++;
    end
    if (starts < cells)
      fail("receive");
    egress_cell_waiting = 1'b0;
    drain();
    repeat (20) tick();
    rx_ready = 1'b0;
  endtask : recv

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(93));
    repeat (16) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1)
      begin
        rst_n = 1'b0;
        cell_54 = 1'b0;
        repeat (2) tick();
        rst_n = 1'b1;
        chk({14'h0, w_adr, r_adr}, 24'h00_0000, "reset counts");
        chk({link.egress_byte_out, w_data}, 24'h00_0000, "reset data");
      end
      tick();
      fork
        send(2);
        begin
          repeat (20) tick();
          chk(24'(link.ingress_select_n), 24'h00_0001, "held off");
          chk(24'(w_phy_act), 24'h00_0000, "port idle");
          write_ready = 1'b1;
        end
      join
      repeat (3) tick();
      send(1);
      drain();
      $display("test ingress mode %0d done", m);
      recv(2);
      $display("test egress mode %0d done", m);
      write_ready = 1'b0;
    end
    results();
  end

endmodule : test_utopia_l1_phy_cell_port

`default_nettype wire
